/* File: bcu_branch_ctrl.sv */
// Program-flow control: jumps, calls, returns, conditional branches
// Contract
// RULE1: short jump: two bytes, signed offset byte
// RULE2: long jump loads 16-bit absolute target
// RULE3: page jump: three bits in opcode, eight after
// RULE4: page jump replaces low 11 PC bits
// RULE5: table jump target is pointer plus accumulator
// RULE6: long call 16-bit, page call 2K block
// RULE7: return resumes after the calling instruction
// RULE8: interrupt return also reports service finished
// RULE9: conditional branch offset spans -128 to +127
// RULE10: zero branches test accumulator directly
// RULE11: decrement operand, write back, branch if nonzero
// RULE12: compare branch taken only when bytes differ
// RULE13: compare sets carry when first is lower
// RULE14: flow instructions two cycles, no-op one
// RULE15: clock generator sequences machine cycle states
// RULE16: taken offset added as two's complement
// RULE17: six states of two clocks each
// RULE18: calls push next address low first; returns pop
`timescale 1ns/1ps
module bcu_branch_ctrl #(
    parameter int STK_DEPTH = bcu_pkg::STK_DEPTH_DEF
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // Instruction request
    input  wire bcu_pkg::bcu_req_t req,
    input  wire logic             req_valid,
    output logic                  req_ready,
    // Interrupt controller
    input  wire logic             irq_active,
    // Instruction result
    output bcu_pkg::bcu_rsp_t     rsp,
    output logic                  rsp_valid,
    // Machine cycle timing
    output logic [2:0]            mc_state,
    output logic                  mc_phase,
    output logic                  busy
);
    import bcu_pkg::*;

    localparam int SPW   = $clog2(STK_DEPTH);
    localparam int A_ONE = CLK_PER_MC;
    localparam int A_TWO = 2 * CLK_PER_MC;

    // Stack must hold at least one return address, power of two
    if (STK_DEPTH < 2 || (1 << SPW) != STK_DEPTH) begin : g_chk
        $error("STK_DEPTH must be a power of two, at least 2");
    end

    logic             rst_meta_q;
    logic             rst_n;
    logic [2:0]       mc_state_q;
    logic             mc_phase_q;
    logic             mc_start;
    logic             mc_end;
    bcu_state_t       fsm_q;
    logic             accept;
    logic [PC_W-1:0]  rel1;
    logic [PC_W-1:0]  rel2;
    logic [PC_W-1:0]  page_tgt;
    logic [PC_W-1:0]  pop_addr;
    logic [7:0]       dec_val;
    bcu_rsp_t         dec;
    logic             dec_two;
    logic             dec_push;
    logic             dec_pop;
    bcu_rsp_t         pend_q;
    logic             two_q;
    logic [7:0]       op_q;
    bcu_rsp_t         rsp_q;
    logic             rsp_valid_q;
    logic [7:0]       stk_q [STK_DEPTH];
    logic [SPW-1:0]   sp_q;

    // Reset release through two flip-flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // State generator: six states, two clocks each
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mc_state_q <= MC_FIRST;
            mc_phase_q <= 1'b0;
        end else begin
            mc_phase_q <= ~mc_phase_q;                   // [RULE17]
            if (mc_phase_q) begin
                mc_state_q <= (mc_state_q == MC_LAST) ? MC_FIRST
                              : mc_state_q + 3'h1;       // [RULE15]
            end
        end
    end

    assign mc_start  = (mc_state_q == MC_FIRST) && !mc_phase_q;
    assign mc_end    = (mc_state_q == MC_LAST) && mc_phase_q;
    assign mc_state  = mc_state_q;
    assign mc_phase  = mc_phase_q;
    assign req_ready = rst_n && (fsm_q == BCU_IDLE) && mc_start; // Shut in reset
    assign accept    = req_ready && req_valid;
    assign busy      = (fsm_q != BCU_IDLE);

    // Target candidates, offsets sign extended
    assign rel1 = req.next_pc + {{8{req.byte1[7]}}, req.byte1}; // [RULE16]
    assign rel2 = req.next_pc + {{8{req.byte2[7]}}, req.byte2}; // [RULE9]
    assign page_tgt = {req.next_pc[PC_W-1:PAGE_BITS],
                       req.opcode[OPC_W-1:PAGE_SEL_W], req.byte1}; // [RULE4]
    assign pop_addr = {stk_q[sp_q - SPW'(1)], stk_q[sp_q - SPW'(2)]};
    assign dec_val  = req.opnd_a - 8'h01;

    // Opcode decode and execution result
    always_comb begin
        dec      = '0;
        dec.pc   = req.next_pc;
        dec_two  = 1'b1;
        dec_push = 1'b0;
        dec_pop  = 1'b0;
        case (req.opcode)
            OPC_SHORT_JMP: dec.pc = rel1;                  // [RULE1]
            OPC_LONG_JMP:  dec.pc = {req.byte1, req.byte2}; // [RULE2]
            OPC_TABLE_JMP: dec.pc = req.data_pointer_register + {8'h00, req.acc}; // [RULE5]
            OPC_LONG_CALL: begin
                dec.pc   = {req.byte1, req.byte2};         // [RULE6]
                dec_push = 1'b1;
            end
            OPC_SUB_RET: begin
                dec.pc  = pop_addr;                        // [RULE7]
                dec_pop = 1'b1;
            end
            OPC_IRQ_RET: begin
                dec.pc       = pop_addr;
                dec_pop      = 1'b1;
                dec.irq_done = irq_active;                 // [RULE8]
            end
            OPC_NO_OP: dec_two = 1'b0;                     // [RULE14]
            OPC_ACC_ZERO: begin
                if (req.acc == 8'h00) dec.pc = rel1;       // [RULE10]
            end
            OPC_ACC_NZERO: begin
                if (req.acc != 8'h00) dec.pc = rel1;       // [RULE10]
            end
            OPC_DEC_BRANCH: begin
                dec.wb_data = dec_val;                     // [RULE11]
                dec.wb_we   = 1'b1;
                if (dec_val != 8'h00) dec.pc = rel2;
            end
            OPC_CMP_BRANCH: begin
                dec.carry    = req.opnd_a < req.opnd_b;    // [RULE13]
                dec.carry_we = 1'b1;
                if (req.opnd_a != req.opnd_b) dec.pc = rel2; // [RULE12]
            end
            default: begin
                if (req.opcode[PAGE_SEL_W-1:0] == PAGE_JMP_SEL) begin
                    dec.pc = page_tgt;                     // [RULE3]
                end else if (req.opcode[PAGE_SEL_W-1:0] == PAGE_CALL_SEL) begin
                    dec.pc   = page_tgt;                   // [RULE6]
                    dec_push = 1'b1;
                end else begin
                    dec_two = 1'b0;
                end
            end
        endcase
    end

    // Sequencer: one or two machine cycles per instruction
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fsm_q <= BCU_IDLE;
        end else begin
            case (fsm_q)
                BCU_IDLE: if (accept) fsm_q <= BCU_CYC1;
                BCU_CYC1: if (mc_end) fsm_q <= two_q ? BCU_CYC2 : BCU_IDLE;
                BCU_CYC2: if (mc_end) fsm_q <= BCU_IDLE;   // [RULE14]
                default:  fsm_q <= BCU_IDLE;
            endcase
        end
    end

    // Capture decode result at acceptance
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
            two_q  <= 1'b0;
            op_q   <= OPC_NO_OP;
        end else if (accept) begin
            pend_q <= dec;
            two_q  <= dec_two;
            op_q   <= req.opcode;
        end
    end

    // Publish result at end of last machine cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_q       <= '0;
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= 1'b0;
            if (mc_end && (fsm_q == BCU_CYC2
                           || (fsm_q == BCU_CYC1 && !two_q))) begin
                rsp_q       <= pend_q;
                rsp_valid_q <= 1'b1;
            end
        end
    end

    assign rsp       = rsp_q;
    assign rsp_valid = rsp_valid_q;

    // Return address stack, low byte stored first
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= '0;
        end else if (accept && dec_push) begin
            sp_q <= sp_q + SPW'(2);                        // [RULE18]
        end else if (accept && dec_pop) begin
            sp_q <= sp_q - SPW'(2);                        // [RULE18]
        end
    end

    // Stack storage has no reset
    always_ff @(posedge core_clk) begin
        if (accept && dec_push) begin
            stk_q[sp_q]           <= req.next_pc[7:0];     // [RULE18]
            stk_q[sp_q + SPW'(1)] <= req.next_pc[15:8];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Result checks land on the edge that first samples rsp_valid high
    a_short_rel_tgt: assert property ( // [RULE1]
        accept && req.opcode == OPC_SHORT_JMP |->
        ##A_TWO rsp_valid && rsp.pc == $past(rel1, A_TWO))
        else $error("short jump target wrong");
    a_long_abs_tgt: assert property ( // [RULE2]
        accept && req.opcode == OPC_LONG_JMP |->
        ##A_TWO rsp.pc == $past({req.byte1, req.byte2}, A_TWO))
        else $error("long jump target wrong");
    a_page_keep_high: assert property ( // [RULE3]
        rsp_valid && op_q[PAGE_SEL_W-1:0] == PAGE_JMP_SEL
        && op_q != OPC_SHORT_JMP
        |-> rsp.pc[PAGE_BITS-1:PAGE_BITS-3] == op_q[7:5])
        else $error("page jump bits wrong");
    a_table_sum: assert property ( // [RULE5]
        accept && req.opcode == OPC_TABLE_JMP |->
        ##A_TWO rsp.pc == $past(req.data_pointer_register + {8'h00, req.acc}, A_TWO))
        else $error("table jump sum wrong");
    a_call_push: assert property ( // [RULE18]
        accept && dec_push |=> sp_q == $past(sp_q) + SPW'(2))
        else $error("call did not push two bytes");
    // Call followed directly by a return lands back after the call
    a_ret_resume: assert property ( // [RULE7]
        (accept && dec_push) ##A_TWO (accept && dec_pop)
        |-> ##A_TWO rsp.pc == $past(req.next_pc, 2 * A_TWO))
        else $error("return address wrong");
    a_irq_done_src: assert property ( // [RULE8]
        rsp_valid && rsp.irq_done |-> op_q == OPC_IRQ_RET)
        else $error("service end from wrong opcode");
    a_acc_zero_fall: assert property ( // [RULE10]
        accept && req.opcode == OPC_ACC_ZERO && req.acc != 8'h00
        |-> ##A_TWO rsp.pc == $past(req.next_pc, A_TWO))
        else $error("zero branch taken wrongly");
    a_dec_write: assert property ( // [RULE11]
        accept && req.opcode == OPC_DEC_BRANCH |->
        ##A_TWO rsp.wb_we && rsp.wb_data == $past(dec_val, A_TWO))
        else $error("decrement write-back wrong");
    a_cmp_carry: assert property ( // [RULE13]
        accept && req.opcode == OPC_CMP_BRANCH |-> ##A_TWO rsp.carry_we
        && rsp.carry == $past(req.opnd_a < req.opnd_b, A_TWO))
        else $error("compare carry wrong");
    a_nop_one_cycle: assert property ( // [RULE14]
        accept && req.opcode == OPC_NO_OP |-> ##A_ONE rsp_valid)
        else $error("no-op not one machine cycle");
    // Start of cycle after a running phase; skips the held reset state
    a_mc_period: assert property ( // [RULE17]
        mc_start && $past(mc_phase) |-> ##1 (!mc_start)[*8]
        ##1 (!mc_start)[*3] ##1 mc_start)
        else $error("machine cycle not twelve clocks");
endmodule

/* File: bcu_branch_ctrl_tb.sv */
// Self-checking bench for the branch control unit
`timescale 1ns/1ps
// Compare helper: counts every check, reports and counts mismatches
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    fail_count++; $display("Error at %0t: got %h expected %h", \
    $time, (got), (exp)); end end
module bcu_branch_ctrl_tb;
    import bcu_pkg::*;
    // Stimulus and observed signals
    logic             core_clk;
    logic             reset_n;
    logic             req_valid;
    logic             irq_active;
    bcu_req_t         req;
    logic             req_ready;
    logic             rsp_valid;
    logic             busy;
    logic             mc_phase;
    logic [2:0]       mc_state;
    bcu_rsp_t         rsp;
    int               fail_count;
    int               checked;

    // Clock at 125 MHz
    always #4 core_clk = ~core_clk;

    bcu_branch_ctrl dut (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .req        (req),
        .req_valid  (req_valid),
        .req_ready  (req_ready),
        .irq_active (irq_active),
        .rsp        (rsp),
        .rsp_valid  (rsp_valid),
        .mc_state   (mc_state),
        .mc_phase   (mc_phase),
        .busy       (busy)
    );

    // Counts, verdict and end of run
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One instruction: wait for ready, hold request over accept edge
    task automatic exec(input logic [7:0] opc, b1, b2,
                        input logic [15:0] npc, input int cyc);
        int n;
        req.opcode  = opc;
        req.byte1   = b1;
        req.byte2   = b2;
        req.next_pc = npc;
        req_valid   = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 40) begin
            fail_count++;
            report_and_stop();
        end
        @(posedge core_clk);
        n = 0;
        @(negedge core_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
            @(negedge core_clk);
        end
        // Ready cycle plus clocks up to the result
        `CHK(n + 1, cyc)
        if (n == 40) begin
            report_and_stop();
        end
    endtask

    // Conditional branch with offset in both offset positions
    task automatic cond(input logic [7:0] opc, acc, a, b, off,
                        input logic [15:0] exp_pc);
        req.acc    = acc;
        req.opnd_a = a;
        req.opnd_b = b;
        exec(opc, off, off, 16'h0100, 24);
        `CHK(rsp.pc, exp_pc)
    endtask

    // Ready spacing, first state at ready, one-cycle no-op
    task automatic t_timing;
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(mc_state, MC_FIRST)
        `CHK(mc_phase, 1'b0)
        n = 0;
        @(negedge core_clk);
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n + 1, 12)
        exec(OPC_NO_OP, 8'h00, 8'h00, 16'h0001, 12);
        `CHK(busy, 1'b0)
        $display("timing test done");
    endtask

    // Unconditional jumps
    task automatic t_jumps;
        exec(OPC_SHORT_JMP, 8'h80, 8'h00, 16'h1000, 24);
        `CHK(rsp.pc, 16'h0F80)
        exec(OPC_SHORT_JMP, 8'h7F, 8'h00, 16'hFFF0, 24);
        `CHK(rsp.pc, 16'h006F)
        exec(OPC_LONG_JMP, 8'hBE, 8'hEF, 16'h0003, 24);
        `CHK(rsp.pc, 16'hBEEF)
        exec({3'h5, PAGE_JMP_SEL}, 8'h34, 8'h00, 16'hF7FE, 24);
        `CHK(rsp.pc, 16'hF534)
        exec({3'h2, PAGE_JMP_SEL}, 8'h34, 8'h00, 16'h0800, 24);
        `CHK(rsp.pc, 16'h0A34)
        req.acc  = 8'h20;
        req.data_pointer_register = 16'hFFF0;
        exec(OPC_TABLE_JMP, 8'h00, 8'h00, 16'h0200, 24);
        `CHK(rsp.pc, 16'h0010)
        $display("jump test done");
    endtask

    // Nested calls and both return forms
    task automatic t_calls;
        exec(OPC_LONG_CALL, 8'h12, 8'h34, 16'hABCD, 24);
        `CHK(rsp.pc, 16'h1234)
        exec({3'h7, PAGE_CALL_SEL}, 8'h56, 8'h00, 16'h2002, 24);
        `CHK(rsp.pc, 16'h2756)
        exec(OPC_SUB_RET, 8'h00, 8'h00, 16'h2757, 24);
        `CHK(rsp.pc, 16'h2002)
        `CHK(rsp.irq_done, 1'b0)
        irq_active = 1'b1;
        exec(OPC_IRQ_RET, 8'h00, 8'h00, 16'h1235, 24);
        `CHK(rsp.pc, 16'hABCD)
        `CHK(rsp.irq_done, 1'b1)
        irq_active = 1'b0;
        exec(OPC_LONG_CALL, 8'h40, 8'h00, 16'h0777, 24);
        exec(OPC_IRQ_RET, 8'h00, 8'h00, 16'h4001, 24);
        `CHK(rsp.pc, 16'h0777)
        `CHK(rsp.irq_done, 1'b0)
        $display("call test done");
    endtask

    // Conditional branches and their side effects
    task automatic t_cond;
        cond(OPC_ACC_ZERO, 8'h00, 8'h00, 8'h00, 8'h10, 16'h0110);
        cond(OPC_ACC_ZERO, 8'h01, 8'h00, 8'h00, 8'h10, 16'h0100);
        cond(OPC_ACC_NZERO, 8'h01, 8'h00, 8'h00, 8'hF0, 16'h00F0);
        cond(OPC_ACC_NZERO, 8'h00, 8'h00, 8'h00, 8'hF0, 16'h0100);
        cond(OPC_DEC_BRANCH, 8'h00, 8'h01, 8'h00, 8'h80, 16'h0100);
        `CHK(rsp.wb_data, 8'h00)
        `CHK(rsp.wb_we, 1'b1)
        cond(OPC_DEC_BRANCH, 8'h00, 8'h00, 8'h00, 8'h80, 16'h0080);
        `CHK(rsp.wb_data, 8'hFF)
        cond(OPC_CMP_BRANCH, 8'h00, 8'h03, 8'h05, 8'h05, 16'h0105);
        `CHK(rsp.carry, 1'b1)
        `CHK(rsp.carry_we, 1'b1)
        cond(OPC_CMP_BRANCH, 8'h00, 8'h05, 8'h05, 8'h05, 16'h0100);
        `CHK(rsp.carry, 1'b0)
        `CHK(rsp.wb_we, 1'b0)
        cond(OPC_CMP_BRANCH, 8'h00, 8'hF0, 8'h05, 8'h05, 16'h0105);
        `CHK(rsp.carry, 1'b0)
        $display("branch test done");
    endtask

    // Main sequence
    initial begin
        core_clk   = 1'b0;
        reset_n    = 1'b0;
        req_valid  = 1'b0;
        irq_active = 1'b0;
        req        = '0;
        fail_count = 0;
        checked    = 0;
        repeat (2) @(negedge core_clk);
        `CHK(rsp_valid, 1'b0)
        reset_n = 1'b1;
        t_timing();
        t_jumps();
        t_calls();
        t_cond();
        report_and_stop();
    end
endmodule

/* File: bcu_pkg.sv */
// Shared constants and carrier types for the branch control unit
package bcu_pkg;
    // Widths of program counter, opcode and page field
    localparam int PC_W       = 16;
    localparam int OPC_W      = 8;
    localparam int PAGE_BITS  = 11;
    localparam int PAGE_SEL_W = 5;

    // Machine cycle timing on the oscillator input clock
    localparam int OSC_PER_STATE = 2;
    localparam int STATES_PER_MC = 6;
    localparam int CLK_PER_MC    = OSC_PER_STATE * STATES_PER_MC;
    localparam logic [2:0] MC_FIRST = 3'h0;
    localparam logic [2:0] MC_LAST  = 3'(STATES_PER_MC - 1);

    // Internal stack depth in bytes
    localparam int STK_DEPTH_DEF = 16;

    // Opcode encodings
    localparam logic [7:0] OPC_NO_OP      = 8'h00;
    localparam logic [7:0] OPC_SHORT_JMP  = 8'h20;
    localparam logic [7:0] OPC_LONG_JMP   = 8'h22;
    localparam logic [7:0] OPC_TABLE_JMP  = 8'h23;
    localparam logic [7:0] OPC_LONG_CALL  = 8'h24;
    localparam logic [7:0] OPC_SUB_RET    = 8'h25;
    localparam logic [7:0] OPC_IRQ_RET    = 8'h26;
    localparam logic [7:0] OPC_ACC_ZERO   = 8'h27;
    localparam logic [7:0] OPC_ACC_NZERO  = 8'h28;
    localparam logic [7:0] OPC_DEC_BRANCH = 8'h29;
    localparam logic [7:0] OPC_CMP_BRANCH = 8'h2A;
    // Page forms match on the low opcode bits only
    localparam logic [4:0] PAGE_JMP_SEL   = 5'h01;
    localparam logic [4:0] PAGE_CALL_SEL  = 5'h11;

    // Instruction handed over by the core at machine cycle start
    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  byte1;
        logic [7:0]  byte2;
        logic [15:0] next_pc;
        logic [7:0]  acc;
        logic [15:0] data_pointer_register;
        logic [7:0]  opnd_a;
        logic [7:0]  opnd_b;
    } bcu_req_t;

    // Result of one completed instruction
    typedef struct packed {
        logic [15:0] pc;
        logic        carry;
        logic        carry_we;
        logic [7:0]  wb_data;
        logic        wb_we;
        logic        irq_done;
    } bcu_rsp_t;

    // Execution sequencer states
    typedef enum logic [1:0] {
        BCU_IDLE = 2'b00,
        BCU_CYC1 = 2'b01,
        BCU_CYC2 = 2'b10
    } bcu_state_t;
endpackage
